// ---- hdl/eeprom_slave.v ----
// Overview of operation
// - Page write takes up to sixteen data bytes; every byte acknowledged.
// - Nonvolatile programming starts only on the stop ending the write.
// - Page write advances low address nibble only, wrapping, high nibble fixed.
// - More than sixteen bytes wrap and overwrite earlier page bytes.
// - No slave address acknowledge while an internal write cycle runs.
// - Protect command: protect code, write, word and data bytes acknowledged.
// - Protect code with read direction is never acknowledged.
// - Stop after protect command programs protect bit; inputs ignored meanwhile.
// - Protection is permanent; later protect commands are ignored.
// - With protection on, writes to addresses 00 to 7F never execute.
// - Three read types, started with direction bit set to one.
// - Address counter holds last accessed address plus one; page writes wrap it within the page.
// - Current address read acks, sends one byte, stops on nack and stop.
// - Each master acknowledge makes the next sequential byte go out.
// - Sequential read counter wraps from FF to 00.
// - Memory code plus matching strap bits selects this device.
// - Write inhibit pin high blocks every array write.
`timescale 1ns/1ps
`include "eeprom_slave_consts.vh"

module eeprom_slave #(
  parameter PROGRAM_CYCLES = `PROGRAM_CYCLES
) (
  // Clock, reset, enable
  input wire clk,
  input wire arst_n,
  input wire clk_en,
  // Two-wire bus pins
  input wire scl_in,
  input wire sda_in,
  output reg sda_out_q,
  output reg sda_oe_n_q,
  // Straps and write control
  input wire strap_addr_bit0,
  input wire strap_addr_bit1,
  input wire strap_addr_bit2,
  input wire write_inhibit_pin,
  // Status
  output reg busy_q,
  output reg protected_q
);

  // ***************************************************************
  // Local definitions
  // ***************************************************************
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_DEVADDR = 3'd1;
  localparam [2:0] ST_WORDADDR = 3'd2;
  localparam [2:0] ST_WDATA = 3'd3;
  localparam [2:0] ST_RDATA = 3'd4;
  localparam [2:0] ST_RACK = 3'd5;
  localparam [2:0] ST_PROT = 3'd6;
  localparam [31:0] PROG_LAST = PROGRAM_CYCLES - 1;

  // ***************************************************************
  // Input synchronisers
  // ***************************************************************
  reg [5:0] meta_q;
  reg [5:0] sync_q;
  reg scl_old_q;
  reg sda_old_q;
  // Two flops on every pin; straps and inhibit are also asynchronous
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= 6'h3F;
      sync_q <= 6'h3F;
      scl_old_q <= 1'b1;
      sda_old_q <= 1'b1;
    end else if (clk_en) begin
      meta_q <= {write_inhibit_pin, strap_addr_bit2, strap_addr_bit1,
                 strap_addr_bit0, sda_in, scl_in};
      sync_q <= meta_q;
      scl_old_q <= sync_q[0];
      sda_old_q <= sync_q[1];
    end
  end

  wire scl = sync_q[0];
  wire sda = sync_q[1];
  wire [2:0] strap = sync_q[4:2];
  wire inhibit = sync_q[5];
  wire scl_rise = scl & ~scl_old_q;
  wire scl_fall = ~scl & scl_old_q;
  wire start_cond = scl & scl_old_q & sda_old_q & ~sda;
  wire stop_cond = scl & scl_old_q & ~sda_old_q & sda;

  // ***************************************************************
  // Array, page buffer and state
  // ***************************************************************
  reg [7:0] mem [0:`ARRAY_DEPTH-1];
  reg [7:0] page_buf_q [0:(1<<`PAGE_BITS)-1];
  reg [(1<<`PAGE_BITS)-1:0] page_vld_q;
  reg [7:0] page_base_q;
  reg [2:0] state_q;
  reg [3:0] bit_cnt_q;
  reg [7:0] shift_q;
  reg [7:0] addr_cnt_q;
  reg prot_cmd_q;
  reg read_dir_q;
  reg ack_phase_q;
  reg page_dirty_q;
  reg prot_pend_q;
  reg [31:0] prog_cnt_q;
  reg [7:0] rd_byte;
  reg is_mem_q;
  reg is_prot_q;

  // Array holds no reset; cells start erased
  integer i;
  initial begin
    for (i = 0; i < `ARRAY_DEPTH; i = i + 1) begin
      mem[i] = `ERASED_BYTE;
    end
  end

  // Write permission for one address
  function allowed;
    input [7:0] a;
    input inh;
    input prot;
    begin
      allowed = ~inh & ~(prot & ~a[`LOW_HALF_BIT]);
    end
  endfunction

  always @* begin
    rd_byte = mem[addr_cnt_q];
  end

  wire [7:0] rx_byte = {shift_q[6:0], sda};
  wire addr_match = (rx_byte[3:1] == strap);
  wire is_mem = (rx_byte[7:4] == `MEM_CODE) & addr_match;
  wire is_prot = (rx_byte[7:4] == `PROTECT_CODE) & addr_match;

  // ***************************************************************
  // Program cycle commit into the array
  // ***************************************************************
  genvar g;
  generate
    for (g = 0; g < (1 << `PAGE_BITS); g = g + 1) begin : g_commit
      localparam [31:0] SLOT = g;
      // Each buffered slot is written when the program cycle ends
      always @(posedge clk) begin
        if (clk_en && busy_q && prog_cnt_q == PROG_LAST &&
            page_vld_q[g]) begin
          mem[{page_base_q[7:`PAGE_BITS], SLOT[`PAGE_BITS-1:0]}] <=
            page_buf_q[g];
        end
      end
    end
  endgenerate

  // ***************************************************************
  // Bus protocol engine
  // ***************************************************************
  // One engine walks start, address, data and ack phases per SCL edge
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      addr_cnt_q <= 8'h00;
      prot_cmd_q <= 1'b0;
      read_dir_q <= 1'b0;
      ack_phase_q <= 1'b0;
      page_dirty_q <= 1'b0;
      page_vld_q <= {(1<<`PAGE_BITS){1'b0}};
      page_base_q <= 8'h00;
      prot_pend_q <= 1'b0;
      prog_cnt_q <= 32'h0;
      busy_q <= 1'b0;
      protected_q <= 1'b0;
      sda_out_q <= 1'b0; // Open drain: only ever pulls low
      sda_oe_n_q <= 1'b1;
    end else if (clk_en) begin
      if (busy_q) begin
        // Inputs ignored while programming; no ack to polls
        sda_oe_n_q <= 1'b1;
        state_q <= ST_IDLE;
        if (prog_cnt_q == PROG_LAST) begin
          busy_q <= 1'b0;
          prog_cnt_q <= 32'h0;
          page_vld_q <= {(1<<`PAGE_BITS){1'b0}};
          if (prot_pend_q) begin
            protected_q <= 1'b1;
          end
          prot_pend_q <= 1'b0;
        end else begin
          prog_cnt_q <= prog_cnt_q + 32'h1;
        end
      end else if (start_cond) begin
        // Repeated start keeps the address counter for random read
        state_q <= ST_DEVADDR;
        bit_cnt_q <= 4'h0;
        ack_phase_q <= 1'b0;
        sda_oe_n_q <= 1'b1;
      end else if (stop_cond) begin
        state_q <= ST_IDLE;
        sda_oe_n_q <= 1'b1;
        if (page_dirty_q) begin
          busy_q <= 1'b1;
          page_dirty_q <= 1'b0;
        end
        if (prot_pend_q) begin
          busy_q <= 1'b1;
        end
      end else if (state_q != ST_IDLE && scl_rise && !ack_phase_q) begin
        // Sample one data bit; the read shifter moves only on SCL low
        if (state_q != ST_RDATA) begin
          shift_q <= rx_byte;
        end
        bit_cnt_q <= bit_cnt_q + 4'h1;
      end else if (state_q != ST_IDLE && scl_rise && ack_phase_q) begin
        // Ninth clock: master ack decides sequential continuation
        if (state_q == ST_RACK) begin
          if (sda) begin
            state_q <= ST_IDLE;
          end else begin
            state_q <= ST_RDATA;
          end
        end
      end else if (state_q != ST_IDLE && scl_fall) begin
        if (ack_phase_q) begin
          // End of ack slot: release or start driving read data
          ack_phase_q <= 1'b0;
          bit_cnt_q <= 4'h0;
          if (state_q == ST_RDATA) begin
            sda_oe_n_q <= rd_byte[7];
            sda_out_q <= 1'b0;
            shift_q <= {rd_byte[6:0], 1'b1};
            addr_cnt_q <= addr_cnt_q + 8'h1;
          end else begin
            sda_oe_n_q <= 1'b1;
          end
        end else if (bit_cnt_q == 4'h8) begin
          ack_phase_q <= 1'b1;
          case (state_q)
            ST_DEVADDR: begin
              read_dir_q <= shift_q[0];
              if (shift_q[0] && is_mem_q) begin
                state_q <= ST_RDATA;
                sda_oe_n_q <= 1'b0;
              end else if (!shift_q[0] && (is_mem_q || is_prot_q)) begin
                state_q <= ST_WORDADDR;
                prot_cmd_q <= is_prot_q;
                sda_oe_n_q <= 1'b0;
              end else begin
                // Protect code with read, or foreign address
                state_q <= ST_IDLE;
                sda_oe_n_q <= 1'b1;
              end
            end
            ST_WORDADDR: begin
              if (!prot_cmd_q) begin
                addr_cnt_q <= shift_q;
              end
              state_q <= prot_cmd_q ? ST_PROT : ST_WDATA;
              sda_oe_n_q <= 1'b0;
            end
            ST_WDATA: begin
              // Blocked bytes acked but not buffered
              if (allowed(addr_cnt_q, inhibit, protected_q)) begin
                page_buf_q[addr_cnt_q[`PAGE_BITS-1:0]] <= shift_q;
                page_vld_q[addr_cnt_q[`PAGE_BITS-1:0]] <= 1'b1;
                page_base_q <= addr_cnt_q;
                page_dirty_q <= 1'b1;
              end
              addr_cnt_q <= {addr_cnt_q[7:`PAGE_BITS],
                addr_cnt_q[`PAGE_BITS-1:0] + 4'h1};
              sda_oe_n_q <= 1'b0;
            end
            ST_PROT: begin
              // Data byte is a don't care; later commands ignored
              prot_pend_q <= ~protected_q;
              sda_oe_n_q <= 1'b0;
            end
            ST_RDATA: begin
              state_q <= ST_RACK;
              sda_oe_n_q <= 1'b1;
            end
            default: begin
              state_q <= ST_IDLE;
              sda_oe_n_q <= 1'b1;
            end
          endcase
        end else if (state_q == ST_RDATA) begin
          // Shift out next read bit on SCL low
          sda_oe_n_q <= shift_q[7];
          shift_q <= {shift_q[6:0], 1'b1};
        end
      end
    end
  end

  // Address match captured at eighth bit, used at the falling edge
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      is_mem_q <= 1'b0;
      is_prot_q <= 1'b0;
    end else if (clk_en && scl_rise) begin
      is_mem_q <= is_mem;
      is_prot_q <= is_prot;
    end
  end

endmodule // eeprom_slave

// ---- include/eeprom_slave_consts.vh ----
`ifndef EEPROM_SLAVE_CONSTS_VH
`define EEPROM_SLAVE_CONSTS_VH
// Slave address codes in the upper nibble
`define MEM_CODE 4'hA
`define PROTECT_CODE 4'h6
// Page geometry
`define PAGE_BITS 4
`define ARRAY_DEPTH 256
// Lower half boundary bit of the word address
`define LOW_HALF_BIT 7
// Internal program cycle, in microseconds, and clock rate in MHz
`define PROGRAM_CYCLE_TIME_US 10000
`define CLK_MHZ 200
`define PROGRAM_CYCLES (`PROGRAM_CYCLE_TIME_US * `CLK_MHZ)
// Erased cell value
`define ERASED_BYTE 8'hFF
`endif

// ---- sim/eeprom_slave_asserts.sv ----
`timescale 1ns/1ps
// ************************************************
// Port checker for the serial memory slave
// ************************************************
module eeprom_slave_asserts #(
  parameter PROGRAM_CYCLES = 50
) (
  // Clock and reset
  input wire clk,
  input wire arst_n,
  // Bus pins
  input wire scl_in,
  input wire sda_in,
  input wire sda_out_q,
  input wire sda_oe_n_q,
  // Status
  input wire busy_q,
  input wire protected_q
);
  reg [31:0] busy_cnt_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Length of the program cycle, counted here to avoid long repeats
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) busy_cnt_q <= 32'h0;
    else busy_cnt_q <= busy_q ? busy_cnt_q + 32'h1 : 32'h0;
  end
  property p_busy_len;
    $fell(busy_q) |-> (busy_cnt_q + 1 >= PROGRAM_CYCLES) &&
      (busy_cnt_q <= PROGRAM_CYCLES + 1);
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length");
  property p_busy_quiet;
    busy_q |-> sda_oe_n_q;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("busy ack");
  property p_busy_after_stop;
    $rose(busy_q) |-> scl_in && sda_in;
  endproperty
  a_busy_after_stop: assert property (p_busy_after_stop) else $error("early");
  property p_drive_scl_low;
    $changed(sda_oe_n_q) |-> !scl_in;
  endproperty
  a_drive_scl_low: assert property (p_drive_scl_low) else $error("scl hi");
  property p_drive_bounded;
    $fell(sda_oe_n_q) |-> ##[1:400] $rose(sda_oe_n_q);
  endproperty
  a_drive_bounded: assert property (p_drive_bounded) else $error("stuck");
  property p_open_drain;
    !sda_oe_n_q |-> !sda_out_q;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("drives hi");
  property p_prot_sticky;
    protected_q |=> protected_q;
  endproperty
  a_prot_sticky: assert property (p_prot_sticky) else $error("unprot");
  property p_prot_program;
    $rose(protected_q) |-> ##[0:2] (busy_q || $past(busy_q, 3));
  endproperty
  a_prot_program: assert property (p_prot_program) else $error("prot");
endmodule // eeprom_slave_asserts
bind eeprom_slave eeprom_slave_asserts #(.PROGRAM_CYCLES(PROGRAM_CYCLES)) u_chk (
  .clk(clk), .arst_n(arst_n), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out_q(sda_out_q), .sda_oe_n_q(sda_oe_n_q), .busy_q(busy_q),
  .protected_q(protected_q));

// ---- sim/two_wire_host.sv ----
`timescale 1ns/1ps
// ************************************************
// Two-wire bus master model
// ************************************************
module two_wire_host (
  // Clock
  input wire clk,
  // Bus wires
  input wire sda_line,
  output reg scl,
  output reg sda_drv
);
  // Idle bus, clock parked high between frames
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // Phase of eight clocks, above the six-clock minimum
  task w;
    repeat (8) @(negedge clk);
  endtask
  // Start, also used as repeated start
  task start;
    begin
      sda_drv = 1'b1;
      w;
      scl = 1'b1;
      w;
      sda_drv = 1'b0;
      w;
      scl = 1'b0;
    end
  endtask
  task stop;
    begin
      w;
      sda_drv = 1'b0;
      w;
      scl = 1'b1;
      w;
      sda_drv = 1'b1;
      w;
    end
  endtask
  // Nine bits, data changes only while scl is low
  task xfer(input [8:0] o, output [8:0] r);
    integer i;
    begin
      for (i = 8; i >= 0; i = i - 1) begin
        w;
        sda_drv = o[i];
        w;
        scl = 1'b1;
        w;
        r[i] = sda_line;
        scl = 1'b0;
      end
    end
  endtask
endmodule // two_wire_host

// ---- sim/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  reg clk = 1'b0;
  reg arst_n = 1'b0;
  reg inhibit = 1'b0;
  reg [7:0] exp_mem [0:255];
  reg [7:0] cur;
  reg [8:0] r;
  integer errors = 0;
  integer cmp_count = 0;
  integer k;
  wire scl, sda_drv, sda_out_q, sda_oe_n_q, busy_q, protected_q;
  // Open-drain wire with pull-up
  wire sda = sda_drv & (sda_oe_n_q | sda_out_q);
  always #2.5 clk = ~clk;
  two_wire_host u_host (.clk(clk), .sda_line(sda), .scl(scl),
    .sda_drv(sda_drv));
  // Short program cycle keeps polling within a few attempts
  eeprom_slave #(.PROGRAM_CYCLES(400)) i_eeprom_slave (.clk(clk),
    .arst_n(arst_n), .clk_en(1'b1), .scl_in(scl), .sda_in(sda),
    .sda_out_q(sda_out_q), .sda_oe_n_q(sda_oe_n_q),
    .strap_addr_bit0(1'b1), .strap_addr_bit1(1'b0),
    .strap_addr_bit2(1'b1), .write_inhibit_pin(inhibit),
    .busy_q(busy_q), .protected_q(protected_q));
  task conclude;
    begin
      $display("counts: %0d mismatches, %0d compares", errors, cmp_count);
      if (errors == 0 && cmp_count > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  task check(input [8*8-1:0] name, input [7:0] seen, input [7:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("[FAIL] %0s exp %h seen %h", name, exp, seen);
      end
    end
  endtask
  // One byte out, acknowledge compared
  task send(input [7:0] d, input ack);
    begin
      u_host.xfer({d, 1'b1}, r);
      check("ack", {7'h0, ~r[0]}, {7'h0, ack});
    end
  endtask
  // Write burst; blocked bytes leave the expected array untouched
  task wr(input [7:0] a, input integer n, input [7:0] base, input blk);
    integer j;
    begin
      u_host.start;
      send(8'hAA, 1'b1);
      send(a, 1'b1);
      for (j = 0; j < n; j = j + 1) begin
        send(base + j[7:0], 1'b1);
        if (!blk) exp_mem[{a[7:4], a[3:0] + j[3:0]}] = base + j[7:0];
      end
    end
  endtask
  task poll;
    integer n;
    begin
      u_host.stop;
      check("busy", {7'h0, busy_q}, 8'h01);
      for (n = 0; n < 20; n = n + 1) begin
        u_host.start;
        u_host.xfer(9'h155, r);
        u_host.stop;
        if (n == 0) check("poll", {7'h0, r[0]}, 8'h01);
        if (r[0] === 1'b0) n = 99;
      end
      if (n != 100) begin
        errors = errors + 1;
        conclude;
      end
    end
  endtask
  // Stop after blocked data: no program cycle may follow
  task quiet;
    begin
      u_host.stop;
      repeat (20) @(negedge clk);
      check("idle", {7'h0, busy_q}, 8'h00);
    end
  endtask
  task rdseq(input [7:0] a, input integer n);
    integer j;
    begin
      u_host.start;
      send(8'hAA, 1'b1);
      send(a, 1'b1);
      u_host.start;
      send(8'hAB, 1'b1);
      for (j = 0; j < n; j = j + 1) begin
        u_host.xfer({8'hFF, j == n - 1}, r);
        check("data", r[8:1], exp_mem[a + j[7:0]]);
      end
      u_host.stop;
      cur = a + n[7:0];
    end
  endtask
  task t_page;
    begin
      wr(8'h90, 18, 8'h40, 1'b0);
      poll;
      rdseq(8'h90, 16);
      u_host.start;
      send(8'hAB, 1'b1);
      u_host.xfer(9'h1FF, r);
      check("curr", r[8:1], exp_mem[cur]);
      u_host.stop;
      wr(8'h00, 1, 8'h5A, 1'b0);
      poll;
      rdseq(8'hFF, 2);
      $display("t_page done");
    end
  endtask
  task t_guard;
    begin
      inhibit = 1'b1;
      wr(8'hC3, 1, 8'h77, 1'b1);
      quiet;
      inhibit = 1'b0;
      u_host.start;
      send(8'hA4, 1'b0);
      u_host.start;
      send(8'h6B, 1'b0);
      u_host.start;
      send(8'h6A, 1'b1);
      send(8'h00, 1'b1);
      send(8'h00, 1'b1);
      poll;
      check("prot", {7'h0, protected_q}, 8'h01);
      wr(8'h10, 1, 8'h33, 1'b1);
      quiet;
      wr(8'h80, 1, 8'h44, 1'b0);
      poll;
      rdseq(8'h10, 1);
      rdseq(8'h80, 1);
      rdseq(8'hC3, 1);
      u_host.start;
      send(8'h6A, 1'b1);
      send(8'h00, 1'b1);
      send(8'h00, 1'b1);
      quiet;
      $display("t_guard done");
    end
  endtask
  initial begin
    for (k = 0; k < 256; k = k + 1) exp_mem[k] = 8'hFF;
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_page;
    t_guard;
    conclude;
  end
endmodule // testbench
